// >>> encoder_serial_register_port.sv
/*
  encoder side of the serial position link, its bitwise control frame, the
  banked register space and the configuration uart.
  assumes position comes from logic on mclk; ma_clk and cfg_rx are pins.
*/
// Overview of operation
// - latch position on first clock fall
// - drive low as acknowledge until ready
// - start bit one once data ready
// - one control bit, then single cycle data
// - turn, angle, error, warning, crc, msb first
// - timeout holds output low, master gives bit
// - clock and data rest high between cycles
// - crc covers position, error, warning only
// - crc start zero, poly 0x43, inverted
// - control frame after fourteen zero bits
// - write returns read-back value
// - stop bit zero ends control frame
// - low half banked, high half direct
// - register 0x40 selects the bank for link accesses, uart payload gives its own
// - sixty-eight banks exist
// - uart 115200 8n1, reply only
// - sync, node, command, length, payload, checksum
// - length counts payload bytes only
// - checksum is inverted byte sum
// - read reply command 1, one byte
// - write reply status ack or nak
`timescale 1ns/1ps
`default_nettype none
module encoder_serial_register_port #(
  parameter int BUSY_CYCLES = serial_port_pkg::BUSY_CYC,
  parameter int TMO_CYCLES  = serial_port_pkg::TMO_CYC,
  parameter int BIT_CYCLES  = serial_port_pkg::BIT_CYC
) (
  input  wire logic                         mclk,
  input  wire logic                         rst_n,
  input  wire logic                         ma_clk,
  input  wire serial_port_pkg::position_type position,
  input  wire logic                         cfg_rx,
  output logic                              slo,
  output logic                              cfg_tx,
  output logic                              cfg_tx_oe
);
  import serial_port_pkg::*;

  initial begin
    if (BUSY_CYCLES < 1 || TMO_CYCLES < 2 || TMO_CYCLES >= 2**CNT_W || BUSY_CYCLES >= 2**CNT_W) begin
      $error("busy or timeout count out of range");
    end
    if (BIT_CYCLES < 4 || BIT_CYCLES >= 2**UCNT_W) begin
      $error("uart bit time out of range");
    end
  end

  localparam logic [CNT_W-1:0]  BUSY_C = CNT_W'(BUSY_CYCLES);
  localparam logic [CNT_W-1:0]  TMO_C  = CNT_W'(TMO_CYCLES - 1);
  localparam logic [UCNT_W-1:0] BIT_C  = UCNT_W'(BIT_CYCLES - 1);
  localparam logic [UCNT_W-1:0] HALF_C = UCNT_W'(BIT_CYCLES / 2);

  logic [7:0]     mem [0:MEM_WORDS-1];
  logic [7:0]     bank_sel_ff;
  link_state_type lk_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [SH_W-1:0]  sh_ff;
  logic ma_s1_ff, ma_s2_ff, ma_d_ff, rose_ff, slo_ff;
  logic cdm_ff, cdm_vld_ff, cds_ff, cf_act_ff, cf_r_ff, cf_wr_ff;
  logic [3:0] zrun_ff;
  logic [5:0] ci_ff;
  logic [9:0] cf_sh_ff;
  logic [7:0] cf_dat_ff, cds_sh_ff;

  // ----------------------------------------------------------------
  // shared functions
  // ----------------------------------------------------------------
  function automatic logic [5:0] crc6(input logic [34:0] d);
    logic [5:0] c;
    logic       fb;
    c = CRC_INIT;
    for (int i = 34; i >= 0; i--) begin
      fb = d[i] ^ c[5];
      c  = {c[4:0], 1'b0} ^ (fb ? CRC_POLY : 6'h00);
    end
    return c;
  endfunction

  function automatic logic reg_ok(input logic [7:0] bk, input logic [6:0] a);
    return a[6] || (bk < BANK_CNT);
  endfunction

  function automatic logic [12:0] reg_idx(input logic [7:0] bk, input logic [6:0] a);
    return a[6] ? DIRECT_BASE + {7'h00, a[5:0]} : {bk[6:0], a[5:0]};
  endfunction

  function automatic logic [7:0] rd_byte(input logic [7:0] bk, input logic [6:0] a);
    if (a == BANK_SEL_ADR) begin
      return bank_sel_ff;
    end
    return reg_ok(bk, a) ? mem[reg_idx(bk, a)] : 8'h00;
  endfunction

  // ----------------------------------------------------------------
  // link clock sampling
  // ----------------------------------------------------------------
  wire ma_rise = ma_s2_ff & ~ma_d_ff;
  wire ma_fall = ~ma_s2_ff & ma_d_ff;
  wire tmo_end = (lk_ff == LK_TMO) && (cnt_ff == TMO_C);
  wire [5:0] pos_crc = ~crc6(position);

  // two stages before edge detection
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ma_s1_ff <= 1'b1;
      ma_s2_ff <= 1'b1;
      ma_d_ff  <= 1'b1;
    end else begin
      ma_s1_ff <= ma_clk;
      ma_s2_ff <= ma_s1_ff;
      ma_d_ff  <= ma_s2_ff;
    end
  end

  // ----------------------------------------------------------------
  // position frame
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lk_ff   <= LK_IDLE;
      slo_ff  <= 1'b1;
      cnt_ff  <= '0;
      rose_ff <= 1'b0;
      sh_ff   <= '0;
    end else begin
      unique case (lk_ff)
        LK_IDLE: if (ma_fall) begin
          lk_ff   <= LK_ACK;
          sh_ff   <= {cds_ff, position, pos_crc};
          cnt_ff  <= '0;
          rose_ff <= 1'b0;
        end
        LK_ACK: begin
          if (cnt_ff != BUSY_C) cnt_ff <= cnt_ff + 1'b1;
          if (ma_rise) begin
            rose_ff <= 1'b1;
            if (rose_ff && cnt_ff == BUSY_C) begin
              slo_ff <= 1'b1;
              lk_ff  <= LK_SEND;
              cnt_ff <= '0;
            end else begin
              slo_ff <= 1'b0;
            end
          end
        end
        LK_SEND: if (ma_rise && cnt_ff != CNT_W'(SH_W)) begin
          slo_ff <= sh_ff[SH_W-1];
          sh_ff  <= {sh_ff[SH_W-2:0], 1'b0};
          cnt_ff <= cnt_ff + 1'b1;
        end else if (ma_fall && cnt_ff == CNT_W'(SH_W)) begin
          slo_ff <= 1'b0;
          lk_ff  <= LK_TMO;
          cnt_ff <= '0;
        end
        LK_TMO: if (tmo_end) begin
          slo_ff <= 1'b1;
          lk_ff  <= LK_IDLE;
        end else begin
          cnt_ff <= cnt_ff + 1'b1;
        end
      endcase
    end
  end

  // master bit read at timeout end, line level inverted
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cdm_vld_ff <= 1'b0;
      cdm_ff     <= 1'b0;
    end else begin
      cdm_vld_ff <= tmo_end;
      cdm_ff     <= ~ma_s2_ff;
    end
  end

  // ----------------------------------------------------------------
  // control frame
  // ----------------------------------------------------------------
  logic [7:0] cf_reg;
  // a process, not a wire, so that memory writes also wake the lookup
  always_comb begin
    cf_reg = rd_byte(bank_sel_ff, cf_sh_ff[6:0]);
  end
  wire       cf_rw2   = ci_ff == CF_RW + 6'h01;
  wire       cf_abort = (ci_ff == CF_CTS && !cdm_ff)
                     || (cf_rw2 && (cf_r_ff == cdm_ff || cf_sh_ff[9:7] != SLAVE_ID));
  wire       cf_stop  = ci_ff == (cf_wr_ff ? CF_WSTOP : CF_RSTOP);
  wire       rd_load  = cf_rw2 && !cdm_ff && !cf_abort;
  wire       wb_load  = cf_wr_ff && ci_ff == CF_WBK;
  wire       b_we     = cdm_vld_ff && cf_act_ff && cf_wr_ff && ci_ff == CF_WCOM;
  wire [7:0] b_dat    = {cf_dat_ff[6:0], cdm_ff};

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      zrun_ff   <= '0;
      cf_act_ff <= 1'b0;
      ci_ff     <= '0;
      cf_sh_ff  <= '0;
      cf_r_ff   <= 1'b0;
      cf_wr_ff  <= 1'b0;
      cf_dat_ff <= '0;
    end else if (cdm_vld_ff) begin
      if (!cf_act_ff) begin
        if (cdm_ff && zrun_ff == ZERO_RUN) begin
          cf_act_ff <= 1'b1;
          ci_ff     <= CF_CTS;
          cf_wr_ff  <= 1'b0;
        end
        zrun_ff <= cdm_ff ? 4'h0 : (zrun_ff == ZERO_RUN ? zrun_ff : zrun_ff + 4'h1);
      end else begin
        ci_ff <= ci_ff + 6'h01;
        if (cf_abort) begin
          cf_act_ff <= 1'b0;
          zrun_ff   <= 4'h0;
        end else if (cf_stop) begin
          cf_act_ff <= 1'b0;
          zrun_ff   <= ZERO_RUN;
        end
        if (ci_ff >= CF_ID && ci_ff <= CF_ADR_E) cf_sh_ff <= {cf_sh_ff[8:0], cdm_ff};
        if (ci_ff == CF_RW) cf_r_ff <= cdm_ff;
        if (cf_rw2) cf_wr_ff <= cdm_ff;
        cf_dat_ff <= b_dat;
      end
    end
  end

  // slave control bits: register value or read-back, msb first
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cds_ff    <= 1'b0;
      cds_sh_ff <= '0;
    end else if (cdm_vld_ff) begin
      if (cf_act_ff && (rd_load || wb_load)) begin
        cds_ff    <= cf_reg[7];
        cds_sh_ff <= {cf_reg[6:0], 1'b0};
      end else begin
        cds_ff    <= cf_act_ff && !cf_abort && cds_sh_ff[7];
        cds_sh_ff <= {cds_sh_ff[6:0], 1'b0};
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration uart receive and parse
  // ----------------------------------------------------------------
  logic rx_s1_ff, rx_s2_ff, rx_act_ff, rx_vld_ff, tx_act_ff, tx_ff, oe_ff;
  logic [UCNT_W-1:0] rx_cnt_ff, tx_cnt_ff;
  logic [3:0] rx_bit_ff, tx_bit_ff;
  logic [7:0] rx_sh_ff, sum_ff, cmd_ff, rsp_cmd_ff, rsp_dat_ff;
  logic [7:0] pay_ff [0:2];
  logic [15:0] len_ff;
  logic [1:0] pcnt_ff;
  logic [2:0] tx_idx_ff;
  msg_state_type ms_ff;

  wire       chk_ok = rx_vld_ff && ms_ff == MS_CHK && rx_sh_ff == ~sum_ff;
  wire       rd_req = chk_ok && cmd_ff == CMD_RD && len_ff == LEN_RD;
  wire       wr_req = chk_ok && cmd_ff == CMD_WR && len_ff == LEN_WR;
  wire       u_ok   = !pay_ff[0][7] && reg_ok(pay_ff[1], pay_ff[0][6:0]);
  wire       u_we   = wr_req && u_ok && !b_we;
  wire [15:0] len_n = {rx_sh_ff, len_ff[7:0]};

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_s1_ff <= 1'b1;
      rx_s2_ff <= 1'b1;
    end else begin
      rx_s1_ff <= cfg_rx;
      rx_s2_ff <= rx_s1_ff;
    end
  end

  // 8n1 receiver, middle-of-bit sampling, deaf while replying
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_act_ff <= 1'b0;
      rx_vld_ff <= 1'b0;
      rx_cnt_ff <= '0;
      rx_bit_ff <= '0;
      rx_sh_ff  <= '0;
    end else begin
      rx_vld_ff <= 1'b0;
      if (!rx_act_ff) begin
        if (!rx_s2_ff && !tx_act_ff) begin
          rx_act_ff <= 1'b1;
          rx_cnt_ff <= HALF_C;
          rx_bit_ff <= 4'h0;
        end
      end else if (rx_cnt_ff == '0) begin
        rx_cnt_ff <= BIT_C;
        rx_bit_ff <= rx_bit_ff + 4'h1;
        if (rx_bit_ff == 4'h0 && rx_s2_ff) rx_act_ff <= 1'b0;
        else if (rx_bit_ff == 4'h9) begin
          rx_act_ff <= 1'b0;
          rx_vld_ff <= rx_s2_ff;
        end else if (rx_bit_ff != 4'h0) rx_sh_ff <= {rx_s2_ff, rx_sh_ff[7:1]};
      end else begin
        rx_cnt_ff <= rx_cnt_ff - 1'b1;
      end
    end
  end

  // message framing and running byte sum
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ms_ff   <= MS_SYNC;
      sum_ff  <= '0;
      cmd_ff  <= '0;
      len_ff  <= '0;
      pcnt_ff <= '0;
    end else if (rx_vld_ff) begin
      sum_ff <= (ms_ff == MS_SYNC) ? rx_sh_ff : sum_ff + rx_sh_ff;
      unique case (ms_ff)
        MS_SYNC: if (rx_sh_ff == SYNC_BYTE) ms_ff <= MS_NODE;
        MS_NODE: ms_ff <= (rx_sh_ff == NODE_ADR) ? MS_CMD : MS_SYNC;
        MS_CMD: begin
          cmd_ff <= rx_sh_ff;
          ms_ff  <= MS_LENL;
        end
        MS_LENL: begin
          len_ff <= {8'h00, rx_sh_ff};
          ms_ff  <= MS_LENH;
        end
        MS_LENH: begin
          len_ff  <= len_n;
          pcnt_ff <= 2'h0;
          ms_ff   <= (len_n > LEN_WR) ? MS_SYNC : (len_n == 16'h0000 ? MS_CHK : MS_PAY);
        end
        MS_PAY: begin
          pcnt_ff <= pcnt_ff + 2'h1;
          if (16'(pcnt_ff) == len_ff - 16'h0001) ms_ff <= MS_CHK;
        end
        MS_CHK: ms_ff <= MS_SYNC;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rx_vld_ff && ms_ff == MS_PAY) pay_ff[pcnt_ff] <= rx_sh_ff;
  end

  // ----------------------------------------------------------------
  // register writes from both ports, link port first
  // ----------------------------------------------------------------
  wire       we    = b_we || u_we;
  wire [7:0] w_bk  = b_we ? bank_sel_ff : pay_ff[1];
  wire [6:0] w_adr = b_we ? cf_sh_ff[6:0] : pay_ff[0][6:0];
  wire [7:0] w_dat = b_we ? b_dat : pay_ff[2];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) bank_sel_ff <= BANK_SEL_RST;
    else if (we && w_adr == BANK_SEL_ADR) bank_sel_ff <= w_dat;
  end

  always_ff @(posedge mclk) begin
    if (we && w_adr != BANK_SEL_ADR && reg_ok(w_bk, w_adr)) mem[reg_idx(w_bk, w_adr)] <= w_dat;
  end

  // ----------------------------------------------------------------
  // configuration reply transmitter
  // ----------------------------------------------------------------
  wire [7:0] rsp_chk = ~(SYNC_BYTE + NODE_ADR + rsp_cmd_ff + LEN_RSP + rsp_dat_ff);
  logic [7:0] tx_byte;
  always_comb begin
    unique case (tx_idx_ff)
      3'h0:    tx_byte = SYNC_BYTE;
      3'h1:    tx_byte = NODE_ADR;
      3'h2:    tx_byte = rsp_cmd_ff;
      3'h3:    tx_byte = LEN_RSP;
      3'h4:    tx_byte = 8'h00;
      3'h5:    tx_byte = rsp_dat_ff;
      default: tx_byte = rsp_chk;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_act_ff <= 1'b0;
      tx_ff <= 1'b1;
      oe_ff <= 1'b0;
      tx_idx_ff <= '0;
      tx_bit_ff <= '0;
      tx_cnt_ff <= '0;
      rsp_cmd_ff <= '0;
      rsp_dat_ff <= '0;
    end else if (!tx_act_ff) begin
      if (rd_req || wr_req) begin
        tx_act_ff  <= 1'b1;
        oe_ff      <= 1'b1;
        tx_ff      <= 1'b0;
        tx_idx_ff  <= 3'h0;
        tx_bit_ff  <= 4'h0;
        tx_cnt_ff  <= BIT_C;
        rsp_cmd_ff <= cmd_ff;
        rsp_dat_ff <= rd_req ? rd_byte(pay_ff[1], pay_ff[0][6:0]) : (u_we ? STAT_ACK : STAT_NAK);
      end
    end else if (tx_cnt_ff != '0) begin
      tx_cnt_ff <= tx_cnt_ff - 1'b1;
    end else begin
      tx_cnt_ff <= BIT_C;
      if (tx_bit_ff != 4'h9) begin
        tx_bit_ff <= tx_bit_ff + 4'h1;
        tx_ff     <= (tx_bit_ff == 4'h8) ? 1'b1 : tx_byte[tx_bit_ff[2:0]];
      end else if (tx_idx_ff == 3'(RSP_BYTES - 1)) begin
        tx_act_ff <= 1'b0;
        oe_ff     <= 1'b0;
      end else begin
        tx_idx_ff <= tx_idx_ff + 3'h1;
        tx_bit_ff <= 4'h0;
        tx_ff     <= 1'b0;
      end
    end
  end

  assign slo       = slo_ff;
  assign cfg_tx    = tx_ff;
  assign cfg_tx_oe = oe_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_ready_start;
    lk_ff == LK_ACK ##1 lk_ff == LK_SEND;
  endsequence

  a_idle_high: assert property (lk_ff == LK_IDLE |-> slo_ff) else $error("line not high at rest");
  a_pos_latch: assert property (lk_ff == LK_IDLE && ma_fall |=> lk_ff == LK_ACK
    && sh_ff[40:6] == $past(position) && sh_ff[5:0] == ~crc6($past(position))) else $error("bad latch");
  a_ack_low: assert property (lk_ff == LK_ACK && rose_ff |-> !slo_ff) else $error("ack not low");
  a_start_bit: assert property (s_ready_start |-> slo_ff && $past(cnt_ff) == BUSY_C) else $error("bad start");
  a_tmo_low: assert property (lk_ff == LK_TMO |-> !slo_ff) else $error("timeout not low");
  a_tmo_end: assert property (tmo_end |=> lk_ff == LK_IDLE ##1 cdm_vld_ff == 1'b0 && slo_ff)
    else $error("timeout did not end");
  a_frame_open: assert property (cdm_vld_ff && !cf_act_ff && zrun_ff != ZERO_RUN |=> !cf_act_ff)
    else $error("frame opened early");
  a_bank_write: assert property (we && w_adr == BANK_SEL_ADR |=> bank_sel_ff == $past(w_dat))
    else $error("bank not taken");
  a_wr_status: assert property (wr_req && !tx_act_ff |=> rsp_dat_ff == (u_ok && !$past(b_we) ? STAT_ACK : STAT_NAK))
    else $error("bad status");
  a_tx_drive: assert property (tx_act_ff |-> oe_ff) else $error("reply not driven");
endmodule
`default_nettype wire

// >>> serial_port_pkg.sv
/*
  constants, types and state enumerations for the encoder serial and register port.
  assumes a 50 MHz mclk; busy and timeout counts come from the times below, uart bit counts from BAUD.
*/
package serial_port_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int    CLK_HZ   = 50_000_000;
  localparam longint NS_PER_S = 1_000_000_000;
  localparam int    BUSY_NS  = 6500;   // least busy time before the start bit
  localparam int    TMO_NS   = 18000;  // longest link timeout
  localparam int    BUSY_CYC = int'((longint'(BUSY_NS) * CLK_HZ + NS_PER_S - 1) / NS_PER_S);
  localparam int    TMO_CYC  = int'((longint'(TMO_NS) * CLK_HZ) / NS_PER_S);
  localparam int    BAUD     = 115200;
  localparam int    BIT_CYC  = CLK_HZ / BAUD;
  localparam int    HALF_CYC = BIT_CYC / 2;
  localparam int    CNT_W    = 10;
  localparam int    UCNT_W   = 9;
  // ----------------------------------------------------------------
  // position frame
  // ----------------------------------------------------------------
  localparam int         CRC_W    = 6;
  localparam logic [5:0] CRC_POLY = 6'h03;  // 0x43 without its top term
  localparam logic [5:0] CRC_INIT = 6'h00;
  localparam int         SH_W     = 42;     // cds + 35 data bits + crc
  // ----------------------------------------------------------------
  // control frame bit positions
  // ----------------------------------------------------------------
  localparam logic [3:0] ZERO_RUN = 4'hE;
  localparam logic [5:0] CF_CTS   = 6'h01;
  localparam logic [5:0] CF_ID    = 6'h02;
  localparam logic [5:0] CF_ADR_E = 6'h0B;
  localparam logic [5:0] CF_RW    = 6'h10;
  localparam logic [5:0] CF_WCOM  = 6'h19;
  localparam logic [5:0] CF_WBK   = 6'h1A;
  localparam logic [5:0] CF_RSTOP = 6'h1A;
  localparam logic [5:0] CF_WSTOP = 6'h22;
  localparam logic [2:0] SLAVE_ID = 3'h0;
  // ----------------------------------------------------------------
  // register space
  // ----------------------------------------------------------------
  localparam logic [6:0] BANK_SEL_ADR = 7'h40;
  localparam logic [7:0] BANK_SEL_RST = 8'h00;
  localparam logic [7:0] BANK_CNT     = 8'h44;
  localparam int         MEM_WORDS    = 69 * 64;
  localparam logic [12:0] DIRECT_BASE = 13'h1100;
  // ----------------------------------------------------------------
  // configuration messages
  // ----------------------------------------------------------------
  localparam logic [7:0] SYNC_BYTE = 8'h80;
  localparam logic [7:0] NODE_ADR  = 8'h01;
  localparam logic [7:0] CMD_RD    = 8'h01;
  localparam logic [7:0] CMD_WR    = 8'h02;
  localparam logic [15:0] LEN_RD   = 16'h0002;
  localparam logic [15:0] LEN_WR   = 16'h0003;
  localparam logic [7:0] LEN_RSP   = 8'h01;
  localparam logic [7:0] STAT_ACK  = 8'h90;
  localparam logic [7:0] STAT_NAK  = 8'hA0;
  localparam int         RSP_BYTES = 7;

  typedef struct packed {
    logic [15:0] turn_count;
    logic [16:0] angle_within_turn;
    logic        err;
    logic        warn;
  } position_type;

  typedef enum logic [1:0] {LK_IDLE, LK_ACK, LK_SEND, LK_TMO} link_state_type;
  typedef enum logic [2:0] {MS_SYNC, MS_NODE, MS_CMD, MS_LENL, MS_LENH, MS_PAY, MS_CHK} msg_state_type;
endpackage

// >>> link_host_model.sv
/*
  far-side model: link master on ma_clk and config uart host on cfg_rx.
  assumes mclk at 50 MHz and a 160 ns link clock.
*/
`timescale 1ns/1ps
`default_nettype none
module link_host_model #(
  parameter int TMO = 20,
  parameter int BIT = serial_port_pkg::BIT_CYC
) (
  input  wire logic mclk,
  input  wire logic slo,
  input  wire logic cfg_tx,
  output logic      ma_clk,
  output logic      cfg_rx
);
  import serial_port_pkg::*;
  // ----------
  // link master and config uart host
  // ----------
  // both lines rest high until a request
  initial begin
    ma_clk = 1'b1;
    cfg_rx = 1'b1;
  end
  // one clock pulse, slo sampled late in the high phase
  task automatic pulse(output logic b);
    @(posedge mclk) ma_clk <= 1'b1;
    repeat (4) @(posedge mclk);
    @(negedge mclk) b = slo;
    @(posedge mclk) ma_clk <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask
  // latch, ack, start, 42 bits, then timeout carrying cdm as inverted level
  task automatic frame(input logic cdm, output logic [SH_W-1:0] bits, output logic [2:0] ok);
    logic b;
    int   n;
    repeat (4) @(posedge mclk);
    @(posedge mclk) ma_clk <= 1'b0;
    repeat (3) @(posedge mclk);
    pulse(b);
    ok[0] = (b === 1'b0);
    n = 0;
    while (b !== 1'b1 && n < 20) begin
      pulse(b);
      n++;
    end
    ok[0] = ok[0] & (b === 1'b1);
    for (int i = SH_W - 1; i >= 0; i--) pulse(bits[i]);
    if (!cdm) @(posedge mclk) ma_clk <= 1'b1;
    repeat (4) @(posedge mclk);
    @(negedge mclk) ok[1] = (slo === 1'b0);
    repeat (TMO + 8) @(posedge mclk);
    ma_clk <= 1'b1;
    @(negedge mclk) ok[2] = (slo === 1'b1);
  endtask
  // register write over control bits; returns the read-back cds byte
  task automatic ctrl(input logic [6:0] adr, input logic [7:0] dat, output logic [7:0] back);
    logic [SH_W-1:0] bits;
    logic [2:0]      ok;
    logic [34:0]     cdm;
    cdm = {2'b11, SLAVE_ID, adr, 4'h0, 2'b01, dat, 9'h000};
    back = 8'h00;
    for (int i = 0; i < 14; i++) frame(1'b0, bits, ok);
    for (int i = 0; i < 35; i++) begin
      frame(cdm[34-i], bits, ok);
      if (i >= 27) back = {back[6:0], bits[SH_W-1]};
    end
  endtask
  // one 8n1 byte, lsb first
  task automatic send(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge mclk) cfg_rx <= f[i];
      repeat (BIT - 1) @(posedge mclk);
    end
  endtask
  // one byte back, ok low if no start bit comes
  task automatic recv(output logic [7:0] d, output logic ok);
    int n;
    n = 0;
    while (cfg_tx !== 1'b0 && n < 120 * BIT) begin
      @(posedge mclk);
      n++;
    end
    ok = (n < 120 * BIT);
    repeat (BIT / 2) @(posedge mclk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge mclk);
      d[i] = cfg_tx;
    end
    repeat (BIT) @(posedge mclk);
  endtask
  // whole request while listening for the 7-byte reply
  task automatic xfer(input logic [7:0] req [9], input int n, output logic [7:0] rsp [9], output logic ok);
    logic k;
    ok = 1'b1;
    fork
      for (int i = 0; i < n; i++) send(req[i]);
      for (int i = 0; i < 7; i++) begin
        recv(rsp[i], k);
        ok &= k;
      end
    join
  endtask
endmodule
`default_nettype wire

// >>> encoder_serial_register_port_bench.sv
/*
  self-checking bench for the encoder serial and register port.
  assumes link_host_model stands on the link and config pins.
*/
`timescale 1ns/1ps
`default_nettype none
module encoder_serial_register_port_bench;
  import serial_port_pkg::*;
  // ----------
  // harness
  // ----------
  localparam int TMO = 20;
  localparam int BIT = 40;  // short uart bit keeps the run brief
  logic         mclk;
  logic         rst_n;
  logic         ma_clk;
  logic         cfg_rx;
  logic         slo;
  logic         cfg_tx;
  logic         cfg_tx_oe;
  position_type position;
  int           bad_count;
  int           total_checks;
  encoder_serial_register_port #(.BUSY_CYCLES(4), .TMO_CYCLES(TMO), .BIT_CYCLES(BIT))
    u_encoder_serial_register_port (
    .mclk(mclk), .rst_n(rst_n), .ma_clk(ma_clk), .position(position),
    .cfg_rx(cfg_rx), .slo(slo), .cfg_tx(cfg_tx), .cfg_tx_oe(cfg_tx_oe));
  link_host_model #(.TMO(TMO), .BIT(BIT)) u_link_host_model (
    .mclk(mclk), .slo(slo), .cfg_tx(cfg_tx), .ma_clk(ma_clk), .cfg_rx(cfg_rx));
  // 50 MHz clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // serial crc, msb first, poly x^6+x+1, start zero
  function automatic logic [5:0] crc6(input logic [34:0] d);
    logic [5:0] c;
    c = 6'h00;
    for (int i = 34; i >= 0; i--) c = {c[4:0], 1'b0} ^ ((c[5] ^ d[i]) ? 6'h03 : 6'h00);
    return c;
  endfunction
  // inverted byte sum modulo 256
  function automatic logic [7:0] chk(input logic [7:0] b [9], input int n);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < n; i++) s = s + b[i];
    return ~s;
  endfunction
  // position frame, value changed after the latch
  task automatic test_position;
    logic [SH_W-1:0] bits;
    logic [2:0]      ok;
    position_type    p;
    p = '{16'hA5C3, 17'h15A3C, 1'b1, 1'b0};
    position <= p;
    repeat (4) @(posedge mclk);
    fork
      u_link_host_model.frame(1'b0, bits, ok);
      begin
        repeat (12) @(posedge mclk);
        position <= ~p;
      end
    join
    check("ack and start", ok[0], 1);
    check("frame bits", bits, {1'b0, p, ~crc6(p)});
    check("timeout low", ok[1], 1);
    check("rest high", ok[2], 1);
    $display("test_position done");
  endtask
  // bank select written over control frame, read-back returned
  task automatic test_link_write;
    logic [7:0] back;
    u_link_host_model.ctrl(BANK_SEL_ADR, 8'h05, back);
    check("link read-back", back, 8'h05);
    $display("test_link_write done");
  endtask
  // stray byte and bad checksum dropped, then uart read of bank select
  task automatic test_uart_read;
    logic [7:0] req [9];
    logic [7:0] rsp [9];
    logic [7:0] exp [9];
    logic       ok;
    req = '{8'h80, 8'h01, 8'h01, 8'h02, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00};
    req[7] = chk(req, 7);
    exp = '{8'h80, 8'h01, 8'h01, 8'h01, 8'h00, 8'h05, 8'h00, 8'h00, 8'h00};
    exp[6] = chk(exp, 6);
    u_link_host_model.send(8'h55);
    for (int i = 0; i < 7; i++) u_link_host_model.send(req[i]);
    u_link_host_model.send(~req[7]);
    repeat (BIT) @(posedge mclk);
    check("no reply to bad message", cfg_tx_oe, 0);
    u_link_host_model.xfer(req, 8, rsp, ok);
    check("reply seen", ok, 1);
    for (int i = 0; i < 7; i++) check("reply byte", rsp[i], exp[i]);
    check("pin driven", cfg_tx_oe, 1);
    repeat (BIT) @(posedge mclk);
    check("pin released", cfg_tx_oe, 0);
    $display("test_uart_read done");
  endtask
  // uart write acknowledged, read back, then refused past the last bank
  task automatic test_uart_write;
    logic [7:0] req [9];
    logic [7:0] rsp [9];
    logic [7:0] exp [9];
    logic       ok;
    for (int k = 0; k < 3; k++) begin
      req = '{8'h80, 8'h01, 8'h02, 8'h03, 8'h00, 8'h03, (k == 2) ? 8'h44 : 8'h04, 8'h5A, 8'h00};
      if (k == 1) begin
        req[2] = 8'h01;
        req[3] = 8'h02;
        req[7] = chk(req, 7);
      end else begin
        req[8] = chk(req, 8);
      end
      exp = '{8'h80, 8'h01, req[2], 8'h01, 8'h00, (k == 0) ? 8'h90 : (k == 1) ? 8'h5A : 8'hA0, 8'h00, 8'h00, 8'h00};
      exp[6] = chk(exp, 6);
      u_link_host_model.xfer(req, 9 - k % 2, rsp, ok);
      check("write reply seen", ok, 1);
      for (int i = 0; i < 7; i++) check("write reply byte", rsp[i], exp[i]);
      repeat (BIT) @(posedge mclk);
    end
    $display("test_uart_write done");
  endtask
  // hang guard
  initial begin
    repeat (90000) @(posedge mclk);
    bad_count++;
    close_out();
  end
  // reset, then scenarios
  initial begin
    bad_count = 0;
    total_checks = 0;
    rst_n = 1'b0;
    position = '0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (5) @(posedge mclk);
    test_position();
    test_link_write();
    test_uart_read();
    test_uart_write();
    close_out();
  end
endmodule
`default_nettype wire
